// ==== src/fwbsc_pkg.sv ====
// Package for the flash window, boot swap and cache controller.
// Assumes a single 100 MHz core clock and a classic Wishbone register bus.
package fwbsc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_OP_BLOCK = 8'h08;
  localparam logic [7:0] ADDR_WINDOW   = 8'h0c;
  localparam logic [7:0] ADDR_BOOT_SEL = 8'h10;

  // Control register bits (write only, self clearing)
  localparam int CTRL_START_BIT     = 0;
  localparam int CTRL_ERASE_BIT     = 1;
  localparam int CTRL_SEQ_RESET_BIT = 2;
  localparam int CTRL_TOGGLE_BIT    = 3;
  localparam int CTRL_CACHE_ON_BIT  = 4;
  localparam int CTRL_CACHE_OFF_BIT = 5;

  // Status register bits
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_WIN_ERR_BIT  = 1;
  localparam int STAT_BUSY_ERR_BIT = 2;
  localparam int STAT_CACHE_BIT    = 3;
  localparam int STAT_SWAP_BIT     = 4;
  localparam int STAT_REGION_BIT   = 5;

  // Window register fields
  localparam int WIN_START_LSB = 0;
  localparam int WIN_END_LSB   = 16;
  localparam int BLK_W         = 16;

  // Startup-region selection encodings
  localparam logic [1:0] SEL_FOLLOW_STORED = 2'h0;
  localparam logic [1:0] SEL_FORCE_DEFAULT = 2'h1;
  localparam logic [1:0] SEL_FORCE_ALT     = 2'h2;
  localparam logic [1:0] SEL_SWITCH_REGION = 2'h3;

  // Reset values
  localparam logic [1:0]       RST_BOOT_SEL  = SEL_FOLLOW_STORED;
  localparam logic             RST_SWAP_FLAG = 1'h1;
  localparam logic [BLK_W-1:0] RST_WIN       = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CFG_UPDATE_NS   = 50;
  localparam int CFG_UPDATE_CYC  = (CFG_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FWBSC_IDLE,
    FWBSC_OP,
    FWBSC_WIN_UPD,
    FWBSC_SWAP_UPD
  } fwbsc_state_e;

endpackage

// ==== src/fwbsc_sync3.sv ====
// Three-stage synchroniser with agreement filter.
// Assumes an asynchronous level input; output moves only when stages two and three agree.
module fwbsc_sync3 (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } fwbsc_sync_s;

  fwbsc_sync_s r;
  fwbsc_sync_s nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    nxt    = r;
    nxt.s1 = asyncIn;
    nxt.s2 = r.s1;
    nxt.s3 = r.s2;
    if (r.s2 == r.s3)
    begin
      nxt.out = r.s3;
    end
    if (!rst_n)
    begin
      nxt = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    r <= nxt;
  end

  assign syncOut = r.out;

endmodule // fwbsc_sync3

// ==== src/flash_window_boot_swap_ctrl.sv ====
// Flash sequencer control: busy state, reset, protection window, boot swap, cache.
// Assumes a classic Wishbone master on core_clk and a flash macro whose done pin is async.
// Behaviour
// - Busy bit shows a running operation and reads at any time.
// - Sequencer reset is taken any time and returns to idle.
// - Protection window start and end block read back.
// - Software writes a new window start and end block.
// - Program or erase outside the window is refused.
// - Equal start and end removes the window.
// - Window update finishes with a ready pulse.
// - Persistent flag reads 0 for alternate, 1 for default region.
// - Swap inverts flag; new region active only after next reset.
// - Swap finishes with a ready pulse.
// - Selection field: follow flag, force default, force alternate.
// - Writing the selection field changes active region at once.
// - Selection field resets to follow the stored flag.
// - Forcing the selection leaves the persistent flag unchanged.
// - Controls enable and disable the code flash cache.
// - Cache status reads 0 disabled, 1 enabled.
// - New operation while busy is rejected and flagged busy.
module flash_window_boot_swap_ctrl
  import fwbsc_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       porRst_n,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       flashDone,
  output logic                            flashOpStart,
  output logic                            flashOpErase,
  output logic      [fwbsc_pkg::BLK_W-1:0] flashOpBlock,
  output logic                            flashAbort,
  output logic                            flashReadyIrq,
  output logic                            cacheEnable,
  output logic                            bootFromDefault
);
  import fwbsc_pkg::*;

  typedef struct packed {
    fwbsc_state_e     st;
    logic [15:0]      cnt;
    logic [BLK_W-1:0] opBlk;
    logic             opErase;
    logic [BLK_W-1:0] winStart;
    logic [BLK_W-1:0] winEnd;
    logic [BLK_W-1:0] pendStart;
    logic [BLK_W-1:0] pendEnd;
    logic             swapFlag;
    logic             bootLatched;
    logic [1:0]       bootSel;
    logic             cacheEn;
    logic             winErr;
    logic             busyErr;
    logic             doneQ;
    logic             ack;
    logic [31:0]      rdata;
    logic             irq;
    logic             opStart;
    logic             abort;
  } fwbsc_core_s;

  localparam logic [15:0] CFG_CNT = 16'(CFG_UPDATE_CYC);

  fwbsc_core_s r;
  fwbsc_core_s nxt;
  logic        doneSync;
  logic        req;
  logic        wrReq;
  logic [31:0] mask;
  logic [31:0] ctrlW;
  logic [31:0] winW;
  logic [31:0] blkW;
  logic        winActive;
  logic        inWindow;
  logic        activeDefault;
  logic        busy;

  // Flash macro completion comes from another domain
  fwbsc_sync3 u_done_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (flashDone),
    .syncOut  (doneSync)
  );

  // Bus decode and byte-lane merge
  assign req   = wb_cyc_i && wb_stb_i && !r.ack;
  assign wrReq = req && wb_we_i;
  assign mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ctrlW = wb_dat_i & mask;
  assign winW  = (wb_dat_i & mask) | ({r.winEnd, r.winStart} & ~mask);
  assign blkW  = (wb_dat_i & mask) | ({16'h0000, r.opBlk} & ~mask);

  // Window check; equal bounds mean no window, end bound is exclusive
  assign winActive = (r.winStart != r.winEnd);
  assign inWindow  = !winActive || ((r.opBlk >= r.winStart) && (r.opBlk < r.winEnd));

  // Active startup region follows the field at once, stored flag only via latch
  always_comb
  begin
    unique case (r.bootSel)
      SEL_FORCE_DEFAULT: activeDefault = 1'b1;
      SEL_FORCE_ALT:     activeDefault = 1'b0;
      default:           activeDefault = r.bootLatched;
    endcase
  end

  assign busy = (r.st != FWBSC_IDLE);

  // All next-state logic of the block
  always_comb
  begin
    logic startReq;
    logic seqReset;
    logic toggleReq;
    logic winReq;
    logic rise;
    startReq  = 1'b0;
    seqReset  = 1'b0;
    toggleReq = 1'b0;
    winReq    = 1'b0;
    rise      = doneSync && !r.doneQ;
    nxt         = r;
    nxt.ack     = req;
    nxt.irq     = 1'b0;
    nxt.opStart = 1'b0;
    nxt.abort   = 1'b0;
    nxt.doneQ   = doneSync;

    // Register writes
    if (wrReq)
    begin
      unique case (wb_adr_i)
        ADDR_CTRL:
        begin
          startReq  = ctrlW[CTRL_START_BIT];
          seqReset  = ctrlW[CTRL_SEQ_RESET_BIT];
          toggleReq = ctrlW[CTRL_TOGGLE_BIT];
          // Erase level must hold for the operation already running
          if (ctrlW[CTRL_START_BIT] && !busy)
          begin
            nxt.opErase = ctrlW[CTRL_ERASE_BIT];
          end
          if (ctrlW[CTRL_CACHE_ON_BIT])
          begin
            nxt.cacheEn = 1'b1;
          end
          if (ctrlW[CTRL_CACHE_OFF_BIT])
          begin
            nxt.cacheEn = 1'b0;
          end
        end
        ADDR_STATUS:
        begin
          // Write one to clear; a same-cycle set below still wins
          if (ctrlW[STAT_WIN_ERR_BIT])
          begin
            nxt.winErr = 1'b0;
          end
          if (ctrlW[STAT_BUSY_ERR_BIT])
          begin
            nxt.busyErr = 1'b0;
          end
        end
        ADDR_OP_BLOCK:
        begin
          // Target block frozen while an operation runs
          if (!busy)
          begin
            nxt.opBlk = blkW[BLK_W-1:0];
          end
        end
        ADDR_WINDOW:
        begin
          winReq = 1'b1;
          // A refused write must not retarget an update in flight
          if (!busy)
          begin
            nxt.pendStart = winW[WIN_START_LSB +: BLK_W];
            nxt.pendEnd   = winW[WIN_END_LSB +: BLK_W];
          end
        end
        ADDR_BOOT_SEL:
        begin
          // Reserved switch code is ignored, field keeps its value
          if (wb_sel_i[0] && (wb_dat_i[1:0] != SEL_SWITCH_REGION))
          begin
            nxt.bootSel = wb_dat_i[1:0];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Sequencer; reset request overrides everything else
    if (seqReset)
    begin
      nxt.st    = FWBSC_IDLE;
      nxt.cnt   = 16'h0000;
      nxt.abort = busy;
    end
    else if (busy && (startReq || winReq || toggleReq))
    begin
      nxt.busyErr = 1'b1;
    end
    else
    begin
      unique case (r.st)
        FWBSC_IDLE:
        begin
          if (startReq)
          begin
            if (inWindow)
            begin
              nxt.st      = FWBSC_OP;
              nxt.opStart = 1'b1;
            end
            else
            begin
              nxt.winErr = 1'b1;
            end
          end
          else if (winReq)
          begin
            nxt.st  = FWBSC_WIN_UPD;
            nxt.cnt = CFG_CNT;
          end
          else if (toggleReq)
          begin
            nxt.st  = FWBSC_SWAP_UPD;
            nxt.cnt = CFG_CNT;
          end
        end
        FWBSC_OP:
        begin
          if (rise)
          begin
            nxt.st  = FWBSC_IDLE;
            nxt.irq = 1'b1;
          end
        end
        FWBSC_WIN_UPD:
        begin
          nxt.cnt = r.cnt - 16'h0001;
          if (r.cnt == 16'h0001)
          begin
            nxt.st       = FWBSC_IDLE;
            nxt.winStart = r.pendStart;
            nxt.winEnd   = r.pendEnd;
            nxt.irq      = 1'b1;
          end
        end
        FWBSC_SWAP_UPD:
        begin
          nxt.cnt = r.cnt - 16'h0001;
          if (r.cnt == 16'h0001)
          begin
            nxt.st       = FWBSC_IDLE;
            nxt.swapFlag = !r.swapFlag;
            nxt.irq      = 1'b1;
          end
        end
      endcase
    end

    // Read data captured with the acknowledge
    nxt.rdata = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ADDR_STATUS:
        begin
          nxt.rdata[STAT_BUSY_BIT]     = busy;
          nxt.rdata[STAT_WIN_ERR_BIT]  = r.winErr;
          nxt.rdata[STAT_BUSY_ERR_BIT] = r.busyErr;
          nxt.rdata[STAT_CACHE_BIT]    = r.cacheEn;
          nxt.rdata[STAT_SWAP_BIT]     = r.swapFlag;
          nxt.rdata[STAT_REGION_BIT]   = activeDefault;
        end
        ADDR_OP_BLOCK:
        begin
          nxt.rdata[BLK_W-1:0] = r.opBlk;
        end
        ADDR_WINDOW:
        begin
          nxt.rdata = {r.winEnd, r.winStart};
        end
        ADDR_BOOT_SEL:
        begin
          nxt.rdata[1:0] = r.bootSel;
        end
        default:
        begin
        end
      endcase
    end

    // Core reset: stored flag is sampled here, so a swap shows only now
    if (!rst_n)
    begin
      nxt.st          = FWBSC_IDLE;
      nxt.cnt         = 16'h0000;
      nxt.opBlk       = RST_WIN;
      nxt.opErase     = 1'b0;
      nxt.pendStart   = RST_WIN;
      nxt.pendEnd     = RST_WIN;
      nxt.bootSel     = RST_BOOT_SEL;
      nxt.bootLatched = r.swapFlag;
      nxt.cacheEn     = 1'b0;
      nxt.winErr      = 1'b0;
      nxt.busyErr     = 1'b0;
      nxt.doneQ       = 1'b0;
      nxt.ack         = 1'b0;
      nxt.rdata       = 32'h0000_0000;
      nxt.irq         = 1'b0;
      nxt.opStart     = 1'b0;
      nxt.abort       = 1'b0;
    end
    // Power-on resets the stored area as well: window to 0, stored flag to 1
    if (!porRst_n)
    begin
      nxt.winStart    = RST_WIN;
      nxt.winEnd      = RST_WIN;
      nxt.swapFlag    = RST_SWAP_FLAG;
      nxt.bootLatched = RST_SWAP_FLAG;
    end
  end

  always_ff @(posedge core_clk)
  begin
    r <= nxt;
  end

  // Outputs straight from flip-flops, except bootFromDefault, which is decoded from bootSel and bootLatched
  assign wb_ack_o        = r.ack;
  assign wb_dat_o        = r.rdata;
  assign flashOpStart    = r.opStart;
  assign flashOpErase    = r.opErase;
  assign flashOpBlock    = r.opBlk;
  assign flashAbort      = r.abort;
  assign flashReadyIrq   = r.irq;
  assign cacheEnable     = r.cacheEn;
  assign bootFromDefault = activeDefault;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !porRst_n);

  logic pastIdle;
  assign pastIdle = (r.st == FWBSC_IDLE);

  // Sequencer reset in the same cycle cancels a pending completion
  logic seqHit;
  assign seqHit = wrReq && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0]
                  && wb_dat_i[CTRL_SEQ_RESET_BIT];

  busy_status_a: assert property (
    (req && !wb_we_i && wb_adr_i == ADDR_STATUS) |=> wb_dat_o[STAT_BUSY_BIT] == $past(busy))
    else $error("status busy bit wrong");

  seq_reset_a: assert property (
    (wrReq && wb_adr_i == ADDR_CTRL && wb_dat_i[CTRL_SEQ_RESET_BIT] && wb_sel_i[0])
      |=> pastIdle && (flashAbort == $past(busy)))
    else $error("sequencer reset not honoured");

  window_refuse_a: assert property (
    (wrReq && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT]
      && !wb_dat_i[CTRL_SEQ_RESET_BIT] && pastIdle && !inWindow)
      |=> !flashOpStart && r.winErr && pastIdle)
    else $error("operation outside window started");

  window_done_a: assert property (
    (r.st == FWBSC_WIN_UPD && r.cnt == 16'h0001 && !seqHit)
      |=> flashReadyIrq && {r.winEnd, r.winStart} == $past({r.pendEnd, r.pendStart}))
    else $error("window update did not finish");

  swap_flag_a: assert property (
    (r.st == FWBSC_SWAP_UPD && r.cnt == 16'h0001 && !seqHit)
      |=> flashReadyIrq && r.swapFlag != $past(r.swapFlag)
          && r.bootLatched == $past(r.bootLatched))
    else $error("swap not inverted or took effect early");

  force_keep_a: assert property (
    (wrReq && wb_adr_i == ADDR_BOOT_SEL && pastIdle) |=> $stable(r.swapFlag))
    else $error("selection write changed stored flag");

  select_now_a: assert property (
    (wrReq && wb_adr_i == ADDR_BOOT_SEL && wb_sel_i[0] && wb_dat_i[1:0] == SEL_FORCE_ALT)
      |=> !bootFromDefault)
    else $error("forced region not applied at once");

  busy_reject_a: assert property (
    (busy && wrReq && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT]
      && !wb_dat_i[CTRL_SEQ_RESET_BIT]) |=> r.busyErr && !flashOpStart)
    else $error("operation accepted while busy");

  cache_status_a: assert property (
    (req && !wb_we_i && wb_adr_i == ADDR_STATUS) |=> wb_dat_o[STAT_CACHE_BIT] == cacheEnable)
    else $error("cache status mismatch");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  op_seen_c: cover property (flashOpStart ##[1:200] flashReadyIrq);
  win_err_c: cover property ($rose(r.winErr));
  swap_c:    cover property ((r.st == FWBSC_SWAP_UPD) ##[1:20] flashReadyIrq);
  abort_c:   cover property (flashAbort);

endmodule // flash_window_boot_swap_ctrl

// ==== test/test_flash_window_boot_swap_ctrl.sv ====
// Self-checking bench for the flash window, boot swap and cache controller.
// Assumes one core clock, Wishbone answered with a one-cycle ack, flashDone driven here.
module test_flash_window_boot_swap_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import fwbsc_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        porRst_n = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0;
  logic        flashDone = 1'b0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        opStart;
  logic        opErase;
  logic        abortP;
  logic        irq;
  logic        cacheEn;
  logic        bootDef;
  logic [15:0] opBlock;
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed = 65;
  int          nStart = 0;
  int          nIrq = 0;
  int          nAbort = 0;
  int          cycles = 0;
  // Behavioural model of the register state
  int          mStart = 0;
  int          mEnd = 0;
  int          mSwap = 1;
  int          mLatch = 1;
  int          mSel = 0;
  int          mCache = 0;
  int          mWinErr = 0;
  int          mBusyErr = 0;

  flash_window_boot_swap_ctrl flash_window_boot_swap_ctrl_i (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .porRst_n        (porRst_n),
    .wb_cyc_i        (cyc),
    .wb_stb_i        (stb),
    .wb_we_i         (we),
    .wb_adr_i        (adr),
    .wb_sel_i        (sel),
    .wb_dat_i        (wdat),
    .wb_dat_o        (rdat),
    .wb_ack_o        (ack),
    .flashDone       (flashDone),
    .flashOpStart    (opStart),
    .flashOpErase    (opErase),
    .flashOpBlock    (opBlock),
    .flashAbort      (abortP),
    .flashReadyIrq   (irq),
    .cacheEnable     (cacheEn),
    .bootFromDefault (bootDef)
  );

  // 100 MHz core clock
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // Pulse counters on the falling edge, so a task waking at the next rise sees them
  always @(negedge core_clk)
  begin
    cycles++;
    if (opStart === 1'b1) nStart++;
    if (irq === 1'b1) nIrq++;
    if (abortP === 1'b1) nAbort++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; held until ack is sampled high, never assumes latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n == 50) fail_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  function automatic logic actReg();
    return (mSel == 1) ? 1'b1 : (mSel == 2) ? 1'b0 : mLatch[0];
  endfunction

  function automatic logic [31:0] expStat(input int busy);
    return {26'h0, actReg(), mSwap[0], mCache[0], mBusyErr[0], mWinErr[0], busy[0]};
  endfunction

  // Bounded poll of the busy bit
  task automatic waitIdle();
    int n;
    n = 0;
    do
    begin
      wb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 40);
  endtask

  task automatic pulseRst();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    mLatch = mSwap;
    mSel = 0;
    mCache = 0;
    mWinErr = 0;
    mBusyErr = 0;
  endtask

  task automatic setWin(input int s, input int e);
    int q0;
    q0 = nIrq;
    wb(1'b1, ADDR_WINDOW, {e[15:0], s[15:0]});
    // Second write lands while the update runs and must be refused
    wb(1'b1, ADDR_WINDOW, 32'h0001_0002);
    mBusyErr = 1;
    waitIdle();
    mStart = s;
    mEnd = e;
    check(nIrq - q0, 1);
    rchk(ADDR_WINDOW, {e[15:0], s[15:0]});
    rchk(ADDR_STATUS, expStat(0));
    wb(1'b1, ADDR_STATUS, 32'h4);
    mBusyErr = 0;
    $display("window %0d..%0d done", s, e);
  endtask

  // One operation; a second start while busy must be refused
  task automatic runOp(input int blk, input logic ers);
    int s0;
    int q0;
    logic inWin;
    s0 = nStart;
    q0 = nIrq;
    inWin = (mStart == mEnd) || (blk >= mStart && blk < mEnd);
    wb(1'b1, ADDR_OP_BLOCK, blk);
    wb(1'b1, ADDR_CTRL, {30'h0, ers, 1'b1});
    check(nStart - s0, inWin);
    if (inWin)
    begin
      check(opBlock, blk[15:0]);
      check(opErase, ers);
      wb(1'b1, ADDR_CTRL, 32'h1);
      check(opErase, ers);
      mBusyErr = 1;
      rchk(ADDR_STATUS, expStat(1));
      check(nStart - s0, 1);
      flashDone <= 1'b1;
      waitIdle();
      check(nIrq - q0, 1);
      flashDone <= 1'b0;
    end
    else
      mWinErr = 1;
    rchk(ADDR_STATUS, expStat(0));
    wb(1'b1, ADDR_STATUS, 32'h6);
    mWinErr = 0;
    mBusyErr = 0;
    $display("op block %0d done", blk);
  endtask

  initial
  begin
    int s;
    int e;
    int q0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    porRst_n <= 1'b1;
    // Reset values and an unmapped place
    rchk(ADDR_STATUS, expStat(0));
    rchk(ADDR_WINDOW, 32'h0);
    rchk(ADDR_BOOT_SEL, 32'h0);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rchk(8'h20, 32'h0);
    rchk(ADDR_WINDOW, 32'h0);
    $display("reset values done");
    // Random window with boundary blocks
    s = $unsigned($random(seed)) % 16;
    e = s + 1 + $unsigned($random(seed)) % 16;
    // Cache off before any reprogramming
    wb(1'b1, ADDR_CTRL, 32'h20);
    setWin(s, e);
    for (int k = 0; k < 8; k++)
      runOp($unsigned($random(seed)) % 40, k[0]);
    runOp(e, 1'b0);
    runOp(s, 1'b1);
    runOp(s - 1, 1'b0);
    setWin(3, 3);
    runOp(16'h1234, 1'b0);
    // Sequencer reset in mid-operation
    q0 = nAbort;
    wb(1'b1, ADDR_OP_BLOCK, 32'h7);
    wb(1'b1, ADDR_CTRL, 32'h1);
    rchk(ADDR_STATUS, expStat(1));
    wb(1'b1, ADDR_CTRL, 32'h4);
    check(nAbort - q0, 1);
    rchk(ADDR_STATUS, expStat(0));
    $display("sequencer reset done");
    // Cache on, on+off (off wins), then on again before reset
    wb(1'b1, ADDR_CTRL, 32'h10);
    mCache = 1;
    check(cacheEn, 1'b1);
    rchk(ADDR_STATUS, expStat(0));
    wb(1'b1, ADDR_CTRL, 32'h30);
    mCache = 0;
    check(cacheEn, 1'b0);
    rchk(ADDR_STATUS, expStat(0));
    wb(1'b1, ADDR_CTRL, 32'h10);
    mCache = 1;
    $display("cache done");
    // Swap twice; region moves only at reset, overrides leave the flag alone
    for (int i = 0; i < 2; i++)
    begin
      q0 = nIrq;
      wb(1'b1, ADDR_CTRL, 32'h8);
      rchk(ADDR_STATUS, expStat(1));
      waitIdle();
      mSwap = 1 - mSwap;
      check(nIrq - q0, 1);
      check(bootDef, actReg());
      rchk(ADDR_STATUS, expStat(0));
      pulseRst();
      check(cacheEn, 1'b0);
      rchk(ADDR_STATUS, expStat(0));
      rchk(ADDR_BOOT_SEL, 32'h0);
      for (int v = 0; v < 4; v++)
      begin
        wb(1'b1, ADDR_BOOT_SEL, v);
        if (v < 3) mSel = v;
        check(bootDef, actReg());
        rchk(ADDR_BOOT_SEL, mSel);
        rchk(ADDR_STATUS, expStat(0));
      end
      $display("swap pass %0d done", i);
    end
    end_of_test();
  end

endmodule // test_flash_window_boot_swap_ctrl
